// ===== design/asc_pkg.sv
// Package of timing constants and types for the asynchronous SRAM host controller
package asc_pkg;
    localparam int CLK_PERIOD_NS         = 40;
    localparam int POWERUP_WAIT_US       = 100;
    localparam int READ_CYCLE_MIN_NS     = 10;
    localparam int ADDR_TO_VALID_NS      = 10;
    localparam int SELECT_TO_VALID_NS    = 10;
    localparam int DRIVE_TO_VALID_NS     = 5;
    localparam int LANE_TO_VALID_NS      = 5;
    localparam int STROBE_PULSE_MIN_NS   = 7;
    localparam int WDATA_SETUP_NS        = 5;
    localparam int STROBE_LOW_TO_FLOAT_NS = 5;
    localparam int WRITE_CYCLE_MIN_NS    = 10;
    localparam int RETENTION_RECOVERY_NS = 10;
    localparam int DESELECT_TO_SLEEP_NS  = 10;

    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int POWERUP_WAIT_CYC = (POWERUP_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_WAIT_CYC    = cyc_up(ADDR_TO_VALID_NS);
    localparam int READ_GAP_CYC     = cyc_up(READ_CYCLE_MIN_NS);
    localparam int STROBE_CYC       = cyc_up(STROBE_PULSE_MIN_NS);
    localparam int FLOAT_CYC        = cyc_up(STROBE_LOW_TO_FLOAT_NS);
    localparam int WRITE_GAP_CYC    = cyc_up(WRITE_CYCLE_MIN_NS);
    localparam int RECOVERY_CYC     = cyc_up(RETENTION_RECOVERY_NS);
    localparam int CNT_W            = 16;

    typedef enum logic [2:0] {
        ASC_POWERUP,
        ASC_IDLE,
        ASC_READ,
        ASC_WFLOAT,
        ASC_WRITE,
        ASC_WEND,
        ASC_GAP,
        ASC_RECOVER
    } asc_state_type;
endpackage

// ===== design/asc_ctrl.sv
// Host controller that drives an asynchronous 16-bit byte-lane SRAM
// How it works
// (RULE1) Write only while select and strobe overlap
// (RULE2) Device ends write at first strobe rise
// (RULE3) Data setup measured from terminating strobe edge
// (RULE4) A lane enable must join the window
// (RULE5) Device floats pins when deselected or disabled
// (RULE6) Never drive data while device outputs
// (RULE7) Write strobe stays high during reads
// (RULE8) Address valid by select falling edge
// (RULE9) Wait 100 us after power before access
// (RULE10) Data valid 10 ns after address; spacing
// (RULE11) Device holds old data 3 ns
// (RULE12) Valid 10 ns from select, 5 from enable
// (RULE13) Lane data valid 5 ns after enable
// (RULE14) Address set before start, held to end
// (RULE15) Strobes held low 7 ns before end
// (RULE16) Data setup 5 ns; cycle 10 ns
// (RULE17) Output-enable-low write: float plus setup time
// (RULE18) Device sleeps 10 ns after deselect
// (RULE19) Wait 10 ns after retention exit
// (RULE20) Single lane read drives its byte only
// (RULE21) Write only enabled lanes, output enable ignored
// (RULE22) Selected idle keeps pins floating
// (RULE23) Round nanosecond minimums up to cycles
`timescale 1ns/1ps
module asc_ctrl
    import asc_pkg::*;
#(
    parameter int ADDR_W      = 19,
    parameter int DATA_W      = 16,
    parameter int POWERUP_CYC = POWERUP_WAIT_CYC
) (
    // Clock and reset
    input  wire logic              CLK,
    input  wire logic              RST_N,
    // User request
    input  wire logic              REQ_VALID,
    input  wire logic              REQ_WRITE,
    input  wire logic [ADDR_W-1:0] REQ_ADDR,
    input  wire logic [DATA_W-1:0] REQ_WDATA,
    input  wire logic [1:0]        REQ_LANES,
    input  wire logic              RETENTION_EXIT,
    output logic                   REQ_READY,
    output logic                   RD_VALID,
    output logic [DATA_W-1:0]      RD_DATA,
    // Memory pins
    output logic [ADDR_W-1:0]      MEM_ADDR,
    output logic                   MEM_SELECT_N,
    output logic                   MEM_DRIVE_N,
    output logic                   MEM_STROBE_N,
    output logic                   MEM_LOWER_LANE_SEL_N,
    output logic                   MEM_UPPER_LANE_SEL_N,
    input  wire logic [DATA_W-1:0] MEM_DQ_IN,
    output logic [DATA_W-1:0]      MEM_DQ_OUT,
    output logic                   MEM_DQ_OE
);

    asc_state_type state;
    asc_state_type next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [1:0]       lanes;

    wire logic cnt_done  = (cnt == '0);
    // A retention exit wins over a request, so nothing is latched from the dropped request
    wire logic take_req  = (state == ASC_IDLE) && REQ_VALID && (REQ_LANES != 2'h0) && !RETENTION_EXIT;
    // Lane mask for read capture: unselected byte returns zero
    wire logic [DATA_W-1:0] lane_mask = {{(DATA_W/2){lanes[1]}}, {(DATA_W/2){lanes[0]}}}; // [RULE20]

    // Every interval counts whole cycles, rounded up in the package [RULE23]
    always_comb begin
        next_state = state;
        next_cnt   = cnt_done ? cnt : cnt - 16'h1;
        case (state)
            ASC_POWERUP: begin
                if (cnt_done) begin
                    next_state = ASC_IDLE; // [RULE9]
                end
            end
            ASC_IDLE: begin
                if (RETENTION_EXIT) begin
                    next_state = ASC_RECOVER;
                    next_cnt   = CNT_W'(RECOVERY_CYC - 1); // [RULE19]
                end else if (take_req && REQ_WRITE) begin
                    // Output enable stays high, but the float wait keeps it safe either way
                    next_state = ASC_WFLOAT;
                    next_cnt   = CNT_W'(FLOAT_CYC - 1); // [RULE17]
                end else if (take_req) begin
                    next_state = ASC_READ;
                    next_cnt   = CNT_W'(READ_WAIT_CYC); // [RULE10] [RULE12] [RULE13]
                end
            end
            ASC_READ: begin
                if (cnt_done) begin
                    next_state = ASC_GAP;
                    next_cnt   = CNT_W'(READ_GAP_CYC - 1); // [RULE10]
                end
            end
            ASC_WFLOAT: begin
                if (cnt_done) begin
                    next_state = ASC_WRITE;
                    next_cnt   = CNT_W'(STROBE_CYC - 1); // [RULE15] [RULE16]
                end
            end
            ASC_WRITE: begin
                if (cnt_done) begin
                    next_state = ASC_WEND;
                end
            end
            ASC_WEND: begin
                next_state = ASC_GAP;
                next_cnt   = CNT_W'(WRITE_GAP_CYC - 1); // [RULE16]
            end
            ASC_GAP: begin
                if (cnt_done) begin
                    next_state = ASC_IDLE;
                end
            end
            ASC_RECOVER: begin
                if (cnt_done) begin
                    next_state = ASC_IDLE;
                end
            end
            default: begin
                next_state = ASC_IDLE;
                next_cnt   = '0;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state <= ASC_POWERUP;
            cnt   <= CNT_W'(POWERUP_CYC - 1);
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    // Address and lanes latch at acceptance and stay until the cycle closes [RULE8] [RULE14]
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            MEM_ADDR   <= '0;
            MEM_DQ_OUT <= '0;
            lanes      <= 2'h0;
        end else if (take_req) begin
            MEM_ADDR   <= REQ_ADDR;
            MEM_DQ_OUT <= REQ_WDATA;
            lanes      <= REQ_LANES;
        end
    end

    // Pin strobes, all registered
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            MEM_SELECT_N         <= 1'b1;
            MEM_DRIVE_N          <= 1'b1;
            MEM_STROBE_N         <= 1'b1;
            MEM_LOWER_LANE_SEL_N <= 1'b1;
            MEM_UPPER_LANE_SEL_N <= 1'b1;
            MEM_DQ_OE            <= 1'b0;
        end else begin
            // Select and lanes fall together with the address edge, so address is ready by then [RULE8]
            MEM_SELECT_N         <= !(next_state inside {ASC_READ, ASC_WFLOAT, ASC_WRITE});
            MEM_LOWER_LANE_SEL_N <= !((next_state inside {ASC_READ, ASC_WFLOAT, ASC_WRITE}) &&
                                      (take_req ? REQ_LANES[0] : lanes[0])); // [RULE4] [RULE21]
            MEM_UPPER_LANE_SEL_N <= !((next_state inside {ASC_READ, ASC_WFLOAT, ASC_WRITE}) &&
                                      (take_req ? REQ_LANES[1] : lanes[1])); // [RULE4] [RULE21]
            MEM_DRIVE_N          <= !(next_state == ASC_READ);
            // Strobe only low in the write window, never in a read [RULE1] [RULE7]
            MEM_STROBE_N         <= !(next_state == ASC_WRITE);
            // Data drives only once output enable is high and the float time passed [RULE6]
            // Data stays driven through the cycle the strobe rises, giving hold [RULE3]
            MEM_DQ_OE            <= (next_state == ASC_WRITE) || (next_state == ASC_WEND);
        end
    end

    // Sample read data on the last cycle of the access, after the valid time
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            RD_VALID  <= 1'b0;
            RD_DATA   <= '0;
            REQ_READY <= 1'b0;
        end else begin
            RD_VALID  <= (state == ASC_READ) && cnt_done;
            if ((state == ASC_READ) && cnt_done) begin
                RD_DATA <= MEM_DQ_IN & lane_mask; // [RULE20]
            end
            REQ_READY <= (next_state == ASC_IDLE) && !take_req;
        end
    end

endmodule

// ===== sim/asc_ctrl_assertions.sv
// Pin sequencing checks for the SRAM host controller
`timescale 1ns/1ps
module asc_ctrl_assertions #(
    parameter int ADDR_W      = 19,
    parameter int POWERUP_CYC = 4
) (
    // Clock and reset
    input wire logic              CLK,
    input wire logic              RST_N,
    // User side
    input wire logic              REQ_READY,
    input wire logic              RD_VALID,
    // Memory pins
    input wire logic [ADDR_W-1:0] MEM_ADDR,
    input wire logic              MEM_SELECT_N,
    input wire logic              MEM_DRIVE_N,
    input wire logic              MEM_STROBE_N,
    input wire logic              MEM_LOWER_LANE_SEL_N,
    input wire logic              MEM_UPPER_LANE_SEL_N,
    input wire logic [15:0]       MEM_DQ_OUT,
    input wire logic              MEM_DQ_OE
);
    logic [15:0] cnt;
    always_ff @(posedge CLK) begin
        if (!RST_N)
            cnt <= 16'h0;
        else if (cnt != 16'hffff)
            cnt <= cnt + 16'h1;
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    AST_POWERUP: assert property ((REQ_READY || !MEM_SELECT_N) |-> cnt >= POWERUP_CYC)
        else $error("access too early");
    AST_NO_CLASH: assert property (MEM_DQ_OE |-> MEM_DRIVE_N) else $error("bus clash");
    AST_READ_WE_HIGH: assert property (!MEM_DRIVE_N |-> MEM_STROBE_N) else $error("strobe in read");
    AST_WINDOW: assert property (!MEM_STROBE_N |-> !MEM_SELECT_N && MEM_DQ_OE &&
        !(MEM_LOWER_LANE_SEL_N && MEM_UPPER_LANE_SEL_N)) else $error("bad write window");
    AST_ADDR_SETUP: assert property ($fell(MEM_STROBE_N) |-> !$past(MEM_SELECT_N) && $stable(MEM_ADDR))
        else $error("address setup");
    AST_END: assert property ($fell(MEM_STROBE_N) |=> $rose(MEM_STROBE_N) && $rose(MEM_SELECT_N)
        && $stable(MEM_ADDR)) else $error("write end");
    AST_DATA_HOLD: assert property ($rose(MEM_STROBE_N) |-> MEM_DQ_OE && $stable(MEM_DQ_OUT))
        else $error("data hold");
    AST_READ_DONE: assert property ($fell(MEM_DRIVE_N) |-> ##[1:3] RD_VALID) else $error("no read data");
    AST_RD_PULSE: assert property (RD_VALID |=> !RD_VALID) else $error("read pulse");
    cover property ($rose(MEM_STROBE_N));
    cover property (RD_VALID);
    cover property (!MEM_DRIVE_N && MEM_UPPER_LANE_SEL_N);
endmodule
bind asc_ctrl asc_ctrl_assertions #(.ADDR_W(ADDR_W), .POWERUP_CYC(POWERUP_CYC)) asc_ctrl_assertions_i (.*);

// ===== sim/asc_sram_model.sv
// Behavioural byte-lane asynchronous SRAM
`timescale 1ns/1ps
module asc_sram_model (
    // Control pins
    input wire logic [18:0] addr,
    input wire logic        sel_n,
    input wire logic        drv_n,
    input wire logic        wr_n,
    input wire logic [1:0]  lane_n,
    // Host data
    input wire logic [15:0] host_dq,
    input wire logic        host_oe,
    output logic [15:0]     dq
);
    logic [15:0] mem [0:15];
    logic [15:0] rd;
    logic [15:0] last = 16'h0;
    logic [1:0]  lanes;
    logic        armed = 1'b0;
    wire         out_on = !sel_n && !drv_n && wr_n;
    // Late data exposes a host that samples too early
    assign #8 rd = mem[addr[3:0]];
    always @(negedge out_on) last = rd;
    always @* begin
        for (int b = 0; b < 2; b++)
            dq[b*8+:8] = (out_on && !lane_n[b]) ? rd[b*8+:8] : ~last[b*8+:8];
        if (host_oe)
            dq = out_on ? 16'hxxxx : host_dq;
    end
    always @(negedge wr_n) begin
        armed = !sel_n;
        lanes = ~lane_n;
    end
    // The first of select or strobe to rise ends the write
    always @(posedge wr_n or posedge sel_n) begin
        for (int b = 0; b < 2; b++)
            if (armed && lanes[b]) mem[addr[3:0]][b*8+:8] = dq[b*8+:8];
        armed = 1'b0;
    end
endmodule

// ===== sim/test_asc_ctrl.sv
// Self-checking bench for the SRAM host controller
`timescale 1ns/1ps
module test_asc_ctrl;
    localparam int PWR = 4;
    logic        CLK = 1'b0, RST_N = 1'b0, REQ_VALID = 1'b0, REQ_WRITE = 1'b0, RETENTION_EXIT = 1'b0;
    logic [18:0] REQ_ADDR = 19'h0;
    logic [15:0] REQ_WDATA = 16'h0;
    logic [1:0]  REQ_LANES = 2'h0;
    wire         REQ_READY, RD_VALID, MEM_SELECT_N, MEM_DRIVE_N, MEM_STROBE_N, MEM_DQ_OE;
    wire         MEM_LOWER_LANE_SEL_N, MEM_UPPER_LANE_SEL_N;
    wire  [15:0] RD_DATA, MEM_DQ_OUT, MEM_DQ_IN;
    wire  [18:0] MEM_ADDR;
    int          err_count = 0, cmp_count = 0, cyc = 0;
    always #20 CLK = ~CLK;
    asc_ctrl #(.POWERUP_CYC(PWR)) asc_ctrl_i (.*);
    asc_sram_model asc_sram_model_i (.addr(MEM_ADDR), .sel_n(MEM_SELECT_N), .drv_n(MEM_DRIVE_N), .wr_n(MEM_STROBE_N),
        .lane_n({MEM_UPPER_LANE_SEL_N, MEM_LOWER_LANE_SEL_N}), .host_dq(MEM_DQ_OUT), .host_oe(MEM_DQ_OE), .dq(MEM_DQ_IN));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            close_out();
        end
    end
    // Called at a falling edge; waits for REQ_READY, then the request is taken at the next rising edge
    task automatic issue(input logic wr, input logic [18:0] a, input logic [15:0] d, input logic [1:0] ln);
        for (int n = 0; n < 50 && REQ_READY !== 1'b1; n++) @(negedge CLK);
        {REQ_WRITE, REQ_ADDR, REQ_WDATA, REQ_LANES, REQ_VALID} = {wr, a, d, ln, 1'b1};
        @(negedge CLK);
        REQ_VALID = 1'b0;
    endtask
    task automatic rd_chk(input logic [18:0] a, input logic [1:0] ln, input logic [15:0] exp);
        int n;
        issue(1'b0, a, 16'h0, ln);
        for (n = 0; n < 8 && RD_VALID !== 1'b1; n++) @(negedge CLK);
        chk("read latency", 16'(asc_pkg::READ_WAIT_CYC + 1), 16'(n));
        chk("read data", exp, RD_DATA);
    endtask
    task automatic t_power;
        repeat (PWR) begin
            chk("ready", 16'h0, {15'h0, REQ_READY});
            @(negedge CLK);
        end
        chk("ready", 16'h1, {15'h0, REQ_READY});
    endtask
    task automatic t_lanes;
        issue(1'b1, 19'h5, 16'ha5c3, 2'h3);
        issue(1'b1, 19'h5, 16'h1234, 2'h1);
        rd_chk(19'h5, 2'h3, 16'ha534);
        rd_chk(19'h5, 2'h2, 16'ha500);
        rd_chk(19'h5, 2'h1, 16'h0034);
    endtask
    task automatic t_back;
        issue(1'b1, 19'h6, 16'h0f0f, 2'h3);
        issue(1'b1, 19'h7, 16'hf0f0, 2'h3);
        rd_chk(19'h6, 2'h3, 16'h0f0f);
        rd_chk(19'h7, 2'h3, 16'hf0f0);
    endtask
    // A lane-less request and one beside a retention exit must both be dropped
    task automatic t_refuse;
        issue(1'b0, 19'h6, 16'h0, 2'h0);
        @(negedge CLK);
        RETENTION_EXIT = 1'b1;
        issue(1'b0, 19'h7, 16'h0, 2'h3);
        RETENTION_EXIT = 1'b0;
        repeat (3) begin
            chk("select", 16'h1, {15'h0, MEM_SELECT_N});
            @(negedge CLK);
        end
        rd_chk(19'h6, 2'h3, 16'h0f0f);
    endtask
    initial begin
        repeat (16) @(negedge CLK);
        RST_N = 1'b1;
        t_power();
        t_lanes();
        t_back();
        t_refuse();
        close_out();
    end
endmodule
